/* File: hw/owc_pkg.sv */
// Constants and types for the option word configuration decoder.
// Assumes three 13-bit option words held static by the storage array.
package owc_pkg;

  typedef logic [12:0] owc_word_t;

  // Word 0 field positions
  localparam int unsigned W0_NOISE_WIDTH_BIT = 11;
  localparam int unsigned W0_NOISE_DIS_BIT = 10;
  localparam int unsigned W0_RSTPIN_BIT = 9;
  localparam int unsigned W0_CLKS_LSB = 7;
  localparam int unsigned W0_WDT_BIT = 6;
  localparam int unsigned W0_OSC_LSB = 3;
  localparam int unsigned W0_PROT_LSB = 0;
  // Word 1 field positions
  localparam int unsigned W1_SRC_BIT = 12;
  localparam int unsigned W1_TCLK_BIT = 11;
  localparam int unsigned W1_RCM_LSB = 2;
  localparam int unsigned W1_LVR_LSB = 0;
  // Word 2 field positions
  localparam int unsigned W2_TRIM_LSB = 9;
  localparam int unsigned W2_SUB_FAST_BIT = 4;

  // Oscillator mode codes
  localparam logic [2:0] OSC_CODE_XT = 3'h0;
  localparam logic [2:0] OSC_CODE_HIGH_XTAL = 3'h1;
  localparam logic [2:0] OSC_CODE_LOW_XTAL1 = 3'h2;
  localparam logic [2:0] OSC_CODE_LOW_XTAL2 = 3'h3;

  // Instruction period codes and clock counts
  localparam logic [1:0] CLKS_CODE_4 = 2'h0;
  localparam logic [1:0] CLKS_CODE_2 = 2'h1;
  localparam logic [1:0] CLKS_CODE_8 = 2'h2;
  localparam logic [4:0] INSTR_CLK_2 = 5'h02;
  localparam logic [4:0] INSTR_CLK_4 = 5'h04;
  localparam logic [4:0] INSTR_CLK_8 = 5'h08;
  localparam logic [4:0] INSTR_CLK_16 = 5'h10;

  // Internal RC frequency codes and nominal MHz
  localparam logic [1:0] RCM_CODE_4M = 2'h0;
  localparam logic [1:0] RCM_CODE_16M = 2'h1;
  localparam logic [1:0] RCM_CODE_8M = 2'h2;
  localparam logic [4:0] RC_MHZ_1 = 5'h01;
  localparam logic [4:0] RC_MHZ_4 = 5'h04;
  localparam logic [4:0] RC_MHZ_8 = 5'h08;
  localparam logic [4:0] RC_MHZ_16 = 5'h10;

  // Low-voltage reset level codes
  localparam logic [1:0] LVR_CODE_OFF = 2'h0;
  localparam logic [1:0] LVR_CODE_2V7 = 2'h1;
  localparam logic [1:0] LVR_CODE_3V5 = 2'h2;

  // Noise filter widths in oscillator periods
  localparam logic [5:0] NR_SHORT_CYC = 6'h08;
  localparam logic [5:0] NR_LONG_CYC = 6'h20;

  // Reset values
  localparam logic INT_IDLE_LEVEL = 1'h1;
  localparam logic [5:0] PIN_SYNC_RST = 6'h18;

  typedef enum logic [2:0] {
    OSC_XT, OSC_HIGH_XTAL, OSC_LOW_XTAL1, OSC_LOW_XTAL2, OSC_INT_RC, OSC_EXT_RC
  } owc_osc_e;

  typedef struct packed {
    owc_osc_e osc_mode;
    logic rc_clock_output;
    logic osc_pins_dedicated;
    logic osc_input_gpio;
    logic noise_pulse_short;
    logic noise_reject_on;
    logic reset_pin_select;
    logic [4:0] instr_clocks;
    logic watchdog_enable;
    logic code_protect;
    logic rc_freq_source_sel;
    logic [1:0] rc_freq_sel;
    logic timer_clock_pin_sel;
    logic [1:0] lvr_sel;
    logic sub_osc_fast;
    logic [3:0] sub_osc_trim;
  } owc_cfg_s;

  localparam owc_cfg_s CFG_RESET = '0;

endpackage : owc_pkg

/* File: hw/owc_noise_filter.sv */
// Pulse-width noise filter for the external interrupt pin.
// Assumes pin_i is already synchronised to clk_i.
module owc_noise_filter
  import owc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Control
  input wire logic bypass_i,
  input wire logic short_i,
  // Pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);
  logic [5:0] cnt_reg;
  logic level_reg;
  logic [5:0] need;

  assign need = short_i ? NR_SHORT_CYC : NR_LONG_CYC;
  assign level_o = level_reg;

  // Unless bypassed, level only moves after the pin differs for the full width
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 6'h00;
      level_reg <= INT_IDLE_LEVEL;
    end else if (clk_en_i) begin
      if (bypass_i || pin_i == level_reg) begin
        cnt_reg <= 6'h00;
        level_reg <= pin_i;
      end else if (cnt_reg + 6'h01 >= need) begin
        cnt_reg <= 6'h00;
        level_reg <= pin_i;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i iff clk_en_i); endclocking
  default disable iff (rst_i);

  chk_short_accept: assert property (
    (!bypass_i && short_i && pin_i != level_o)[*8] |=> level_o == $past(pin_i))
    else $error("short pulse not accepted after 8 periods");
  chk_count_bound: assert property (
    !bypass_i |-> cnt_reg < need)
    else $error("filter count passed its width");

endmodule : owc_noise_filter

/* File: hw/owc_config_decoder.sv */
// Option word configuration decoder: latches the three option words at
// reset, drives static controls, filters the external interrupt and
// handles comparator wake. Assumes words are static from storage.
module owc_config_decoder
  import owc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Option words from storage
  input wire owc_pkg::owc_word_t word0_i,
  input wire owc_pkg::owc_word_t word1_i,
  input wire owc_pkg::owc_word_t word2_i,
  // Core state and runtime controls
  input wire logic sleep_i,
  input wire logic cmp_enable_i,
  input wire logic cmp_flag_clr_i,
  input wire logic [1:0] runtime_rc_sel_i,
  // Asynchronous pins and analog levels
  input wire logic cmp_out_i,
  input wire logic ext_int_pin_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic [2:0] vdd_ok_i,
  // Decoded configuration
  output owc_pkg::owc_cfg_s cfg_o,
  output logic cfg_valid_o,
  output logic [1:0] rc_freq_sel_o,
  output logic [4:0] rc_freq_mhz_o,
  // Reset, timing and events
  output logic core_reset_o,
  output logic instr_tick_o,
  output logic ext_int_o,
  output logic cmp_flag_o,
  output logic wake_o
);

  typedef enum logic {ST_LOAD, ST_RUN} owc_state_e;

  owc_state_e state_reg;
  owc_cfg_s cfg_reg;
  logic cfg_valid_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic cmp_s;
  logic int_s;
  logic rst_n_s;
  logic [2:0] vdd_s;
  logic cmp_prev_reg;
  logic cmp_change;
  logic cmp_flag_reg;
  logic wake_reg;
  logic nr_bypass;
  logic filt_q;
  logic filt_d1_reg;
  logic ext_int_reg;
  logic lvr_low;
  logic ext_rst;
  logic core_reset_reg;
  logic [3:0] tick_cnt_reg;
  logic instr_tick_reg;
  logic [1:0] rc_sel_reg;
  logic [4:0] rc_mhz_reg;
  logic [1:0] rc_sel_next;
  logic [4:0] rc_mhz_next;

  // Words decode; fixed bits and RC trim bits are ignored
  function automatic owc_cfg_s decode_words(input owc_word_t w0, input owc_word_t w1,
                                            input owc_word_t w2);
    owc_cfg_s c;
    logic [2:0] osc;
    logic [1:0] clks;
    c = CFG_RESET;
    osc = w0[W0_OSC_LSB +: 3];
    clks = w0[W0_CLKS_LSB +: 2];
    case (osc)
      OSC_CODE_XT: c.osc_mode = OSC_XT;
      OSC_CODE_HIGH_XTAL: c.osc_mode = OSC_HIGH_XTAL;
      OSC_CODE_LOW_XTAL1: c.osc_mode = OSC_LOW_XTAL1;
      OSC_CODE_LOW_XTAL2: c.osc_mode = OSC_LOW_XTAL2;
      default: c.osc_mode = osc[1] ? OSC_EXT_RC : OSC_INT_RC;
    endcase
    c.rc_clock_output = osc[2] & osc[0];
    c.osc_pins_dedicated = (c.osc_mode != OSC_INT_RC);
    c.osc_input_gpio = (c.osc_mode == OSC_INT_RC);
    c.noise_pulse_short = w0[W0_NOISE_WIDTH_BIT];
    c.noise_reject_on = ~w0[W0_NOISE_DIS_BIT] & (osc[2] | ~osc[1]);
    c.reset_pin_select = w0[W0_RSTPIN_BIT];
    case (clks)
      CLKS_CODE_4: c.instr_clocks = INSTR_CLK_4;
      CLKS_CODE_2: c.instr_clocks = INSTR_CLK_2;
      CLKS_CODE_8: c.instr_clocks = INSTR_CLK_8;
      default: c.instr_clocks = INSTR_CLK_16;
    endcase
    c.watchdog_enable = w0[W0_WDT_BIT];
    // Mixed codes protect too: failing safe beats leaking code
    c.code_protect = |w0[W0_PROT_LSB +: 3];
    c.rc_freq_source_sel = w1[W1_SRC_BIT];
    c.rc_freq_sel = w1[W1_RCM_LSB +: 2];
    c.timer_clock_pin_sel = w1[W1_TCLK_BIT];
    c.lvr_sel = w1[W1_LVR_LSB +: 2];
    c.sub_osc_fast = w2[W2_SUB_FAST_BIT];
    c.sub_osc_trim = w2[W2_TRIM_LSB +: 4];
    return c;
  endfunction : decode_words

  // Two-stage synchronisers for pins and analog level detectors
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= PIN_SYNC_RST;
      sync2_reg <= PIN_SYNC_RST;
    end else if (clk_en_i) begin
      sync1_reg <= {cmp_out_i, ext_int_pin_i, ext_reset_pin_n_i, vdd_ok_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign cmp_s = sync2_reg[5];
  assign int_s = sync2_reg[4];
  assign rst_n_s = sync2_reg[3];
  assign vdd_s = sync2_reg[2:0];

  // Words are taken once, on the first enabled edge after reset.
  // No write path exists, so software cannot alter them.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_LOAD;
      cfg_reg <= CFG_RESET;
      cfg_valid_reg <= 1'h0;
    end else if (clk_en_i) begin
      case (state_reg)
        ST_LOAD: begin
          cfg_reg <= decode_words(word0_i, word1_i, word2_i);
          cfg_valid_reg <= 1'h1;
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  assign cfg_o = cfg_reg;
  assign cfg_valid_o = cfg_valid_reg;

  // Reset sources: load pending, low supply, external reset pin
  always_comb begin
    case (cfg_reg.lvr_sel)
      LVR_CODE_OFF: lvr_low = 1'h0;
      LVR_CODE_2V7: lvr_low = ~vdd_s[0];
      LVR_CODE_3V5: lvr_low = ~vdd_s[1];
      default: lvr_low = ~vdd_s[2];
    endcase
  end

  assign ext_rst = cfg_reg.reset_pin_select & ~rst_n_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_reg <= 1'h1;
    end else if (clk_en_i) begin
      core_reset_reg <= ~cfg_valid_reg | lvr_low | ext_rst;
    end
  end

  assign core_reset_o = core_reset_reg;

  // Instruction cycle tick from the decoded period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 4'h0;
      instr_tick_reg <= 1'h0;
    end else if (clk_en_i) begin
      if (core_reset_reg) begin
        tick_cnt_reg <= 4'h0;
        instr_tick_reg <= 1'h0;
      end else if ({1'h0, tick_cnt_reg} == cfg_reg.instr_clocks - 5'h01) begin
        tick_cnt_reg <= 4'h0;
        instr_tick_reg <= 1'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
        instr_tick_reg <= 1'h0;
      end
    end
  end

  assign instr_tick_o = instr_tick_reg;

  // Internal RC frequency: option field or runtime bank register
  always_comb begin
    rc_sel_next = cfg_reg.rc_freq_source_sel ? runtime_rc_sel_i
                                             : cfg_reg.rc_freq_sel;
    case (rc_sel_next)
      RCM_CODE_4M: rc_mhz_next = RC_MHZ_4;
      RCM_CODE_16M: rc_mhz_next = RC_MHZ_16;
      RCM_CODE_8M: rc_mhz_next = RC_MHZ_8;
      default: rc_mhz_next = RC_MHZ_1;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_sel_reg <= RCM_CODE_4M;
      rc_mhz_reg <= RC_MHZ_4;
    end else if (clk_en_i) begin
      rc_sel_reg <= rc_sel_next;
      rc_mhz_reg <= rc_mhz_next;
    end
  end

  assign rc_freq_sel_o = rc_sel_reg;
  assign rc_freq_mhz_o = rc_mhz_reg;

  // Filter bypassed when disabled, asleep, or in a low crystal mode.
  // Asleep the raw pin still raises ext_int_o but does not drive wake_o; only the width check is lost.
  assign nr_bypass = ~cfg_reg.noise_reject_on | sleep_i
                     | (cfg_reg.osc_mode == OSC_LOW_XTAL1)
                     | (cfg_reg.osc_mode == OSC_LOW_XTAL2);

  owc_noise_filter i_owc_noise_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .bypass_i(nr_bypass),
    .short_i(cfg_reg.noise_pulse_short),
    .pin_i(int_s),
    .level_o(filt_q)
  );

  // Falling edge of the filtered level raises one pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_d1_reg <= INT_IDLE_LEVEL;
      ext_int_reg <= 1'h0;
    end else if (clk_en_i) begin
      filt_d1_reg <= filt_q;
      ext_int_reg <= filt_d1_reg & ~filt_q;
    end
  end

  assign ext_int_o = ext_int_reg;

  // Comparator change detect; no sleep gating so it stays live asleep
  assign cmp_change = cmp_enable_i & (cmp_s != cmp_prev_reg);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_prev_reg <= 1'h0;
    end else if (clk_en_i) begin
      cmp_prev_reg <= cmp_s;
    end
  end

  // Set wins over clear so a change during the clear is kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_flag_reg <= 1'h0;
    end else if (clk_en_i) begin
      if (cmp_change) begin
        cmp_flag_reg <= 1'h1;
      end else if (cmp_flag_clr_i) begin
        cmp_flag_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg <= 1'h0;
    end else if (clk_en_i) begin
      wake_reg <= sleep_i & cmp_change;
    end
  end

  assign cmp_flag_o = cmp_flag_reg;
  assign wake_o = wake_reg;

  default clocking cb @(posedge clk_i iff clk_en_i); endclocking
  default disable iff (rst_i);

  sequence s_load_done;
    !cfg_valid_o ##1 cfg_valid_o;
  endsequence

  sequence s_cmp_change_asleep;
    sleep_i && cmp_enable_i && (cmp_s != cmp_prev_reg);
  endsequence

  chk_load_latch: assert property (
    s_load_done |-> cfg_o == decode_words($past(word0_i), $past(word1_i), $past(word2_i)))
    else $error("option words not latched on load");
  chk_cfg_stable: assert property (
    cfg_valid_o ##1 cfg_valid_o |-> $stable(cfg_o))
    else $error("configuration changed after load");
  chk_reset_hold: assert property (
    !cfg_valid_o |=> core_reset_o)
    else $error("core reset released before load");
  chk_lvr_level: assert property (
    cfg_valid_o && cfg_o.lvr_sel == LVR_CODE_3V5 && !vdd_s[1] |=> core_reset_o)
    else $error("low supply did not hold reset");
  chk_osc_pins: assert property (
    s_load_done |-> cfg_o.osc_input_gpio == ($past(word0_i[W0_OSC_LSB + 1 +: 2]) == 2'h2)
                    && cfg_o.osc_pins_dedicated != cfg_o.osc_input_gpio)
    else $error("oscillator pin use inconsistent");
  chk_int_falling: assert property (
    ext_int_o |-> $past(filt_q, 2) && !$past(filt_q))
    else $error("interrupt without falling edge");
  chk_lxt_bypass: assert property (
    cfg_valid_o && cfg_o.osc_mode == OSC_LOW_XTAL2 && int_s != filt_q |=> filt_q == $past(int_s))
    else $error("filter active in low crystal mode");
  chk_cmp_wake: assert property (
    s_cmp_change_asleep |=> wake_o && cmp_flag_o)
    else $error("comparator change did not wake");
  chk_cmp_flag_hold: assert property (
    cmp_flag_o && !cmp_flag_clr_i |=> cmp_flag_o)
    else $error("comparator flag lost");
  chk_instr_tick: assert property (
    instr_tick_o && !core_reset_o && cfg_o.instr_clocks == INSTR_CLK_4 ##1 (!core_reset_o)[*3]
    |=> instr_tick_o)
    else $error("instruction tick spacing wrong");
  chk_rc_source: assert property (
    cfg_valid_o && !cfg_o.rc_freq_source_sel && cfg_o.rc_freq_sel == RCM_CODE_16M
    |=> rc_freq_sel_o == RCM_CODE_16M && rc_freq_mhz_o == RC_MHZ_16)
    else $error("internal RC frequency select wrong");

endmodule : owc_config_decoder

/* File: bench/owc_config_decoder_tb.sv */
// Self-checking bench for the option word configuration decoder.
// Assumes the decoder alone; the bench drives every input itself, off the edge.
module owc_config_decoder_tb
  import owc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic clk_en_i = 1'h1;
  owc_word_t w0 = '0, w1 = '0, w2 = '0;
  logic sleep_i = 1'h0, cmp_enable_i = 1'h0, cmp_flag_clr_i = 1'h0, cmp_out_i = 1'h0;
  logic ext_int_pin_i = 1'h1, ext_reset_pin_n_i = 1'h1;
  logic [1:0] rt_sel = 2'h0;
  logic [2:0] vdd_ok_i = 3'h7;
  owc_cfg_s cfg_o;
  logic cfg_valid_o, core_reset_o, instr_tick_o, ext_int_o, cmp_flag_o, wake_o;
  logic [1:0] rc_freq_sel_o;
  logic [4:0] rc_freq_mhz_o;
  logic [15:0] lfsr = 16'h000B;
  logic [5:0] tbl [6] = '{6'h00, 6'h11, 6'h20, 6'h02, 6'h13, 6'h0C};
  int failures = 0, compares = 0;

  owc_config_decoder i_owc_config_decoder (
    .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .word0_i(w0), .word1_i(w1),
    .word2_i(w2), .sleep_i(sleep_i), .cmp_enable_i(cmp_enable_i),
    .cmp_flag_clr_i(cmp_flag_clr_i), .runtime_rc_sel_i(rt_sel), .cmp_out_i(cmp_out_i),
    .ext_int_pin_i(ext_int_pin_i), .ext_reset_pin_n_i(ext_reset_pin_n_i),
    .vdd_ok_i(vdd_ok_i), .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o),
    .rc_freq_sel_o(rc_freq_sel_o), .rc_freq_mhz_o(rc_freq_mhz_o),
    .core_reset_o(core_reset_o), .instr_tick_o(instr_tick_o), .ext_int_o(ext_int_o),
    .cmp_flag_o(cmp_flag_o), .wake_o(wake_o)
  );

  always #12.5 clk_i = ~clk_i;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  function automatic logic [4:0] clocks_of(input logic [1:0] c);
    return (c == CLKS_CODE_4) ? INSTR_CLK_4 : (c == CLKS_CODE_2) ? INSTR_CLK_2 :
      (c == CLKS_CODE_8) ? INSTR_CLK_8 : INSTR_CLK_16;
  endfunction : clocks_of

  function automatic logic [4:0] mhz_of(input logic [1:0] c);
    return (c == RCM_CODE_4M) ? RC_MHZ_4 : (c == RCM_CODE_16M) ? RC_MHZ_16 :
      (c == RCM_CODE_8M) ? RC_MHZ_8 : RC_MHZ_1;
  endfunction : mhz_of

  function automatic owc_cfg_s exp_cfg(input owc_word_t a, input owc_word_t b,
                                       input owc_word_t c);
    owc_cfg_s e;
    logic int_rc;
    logic [2:0] m;
    m = a[5:3];
    int_rc = m[2] & ~m[1];
    e.osc_mode = m[2] ? (m[1] ? OSC_EXT_RC : OSC_INT_RC) : owc_osc_e'(m);
    e.rc_clock_output = m[2] & m[0];
    e.osc_pins_dedicated = ~int_rc;
    e.osc_input_gpio = int_rc;
    e.noise_pulse_short = a[11];
    e.noise_reject_on = ~a[10] & (m[2] | ~m[1]);
    e.reset_pin_select = a[9];
    e.instr_clocks = clocks_of(a[8:7]);
    e.watchdog_enable = a[6];
    e.code_protect = |a[2:0];
    e.rc_freq_source_sel = b[12];
    e.rc_freq_sel = b[3:2];
    e.timer_clock_pin_sel = b[11];
    e.lvr_sel = b[1:0];
    e.sub_osc_fast = c[4];
    e.sub_osc_trim = c[12:9];
    return e;
  endfunction : exp_cfg

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : step

  task automatic conclude();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk_cfg(input owc_cfg_s got, input owc_cfg_s exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t cfg got %h exp %h", $time, got, exp);
    end
  endtask : chk_cfg

  task automatic chk_val(input logic [4:0] got, input logic [4:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  function automatic logic probe(input int w);
    case (w)
      0: return core_reset_o;
      1: return ext_int_o;
      2: return instr_tick_o;
      default: return wake_o;
    endcase
  endfunction : probe

  // Bounded wait; running out ends the run
  task automatic wait_for(input int w, input logic v, input int n);
    int k;
    k = 0;
    while (probe(w) !== v && k < n) begin
      step();
      k++;
    end
    if (probe(w) !== v) begin
      failures++;
      $display("[ERR] %0t wait %0d ran out", $time, w);
      conclude();
    end
  endtask : wait_for

  task automatic pulses(input int w, input int n, output int c);
    c = 0;
    repeat (n) begin
      step();
      c += (probe(w) === 1'h1);
    end
  endtask : pulses

  // Words set while reset holds, so the first enabled edge sees them stable
  task automatic load(input owc_word_t a, input owc_word_t b, input owc_word_t c);
    owc_cfg_s e;
    e = exp_cfg(a, b, c);
    rst_i = 1'h1;
    w0 = a;
    w1 = b;
    w2 = c;
    step();
    rst_i = 1'h0;
    step();
    chk_cfg(cfg_o, e);
    chk_val(5'(cfg_valid_o), 5'h01, "valid");
    wait_for(0, 1'h0, 12);
  endtask : load

  initial begin
    owc_word_t a, b, c;
    logic [15:0] r;
    logic [5:0] m;
    logic filt;
    int k, n1, n2, thr, wd;
    step(5);
    // Every code of the oscillator, period, RC frequency, RC source and LVR fields first, then random words
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      a = r[12:0];
      r = rnd();
      b = r[12:0];
      r = rnd();
      c = r[12:0];
      rt_sel = r[14:13];
      if (i < 8) begin
        a[5:3] = i[2:0];
        a[8:7] = i[1:0];
        b[3:2] = i[1:0];
        b[1:0] = i[1:0];
        b[12] = i[2];
      end
      a[12] = 1'h0;
      b[10:9] = 2'h3;
      b[8:4] = 5'h00;
      load(a, b, c);
      chk_val(rc_freq_mhz_o, mhz_of(b[12] ? rt_sel : b[3:2]), "mhz");
      wait_for(2, 1'h1, 40);
      k = 0;
      do begin
        step();
        k++;
      end while (instr_tick_o !== 1'h1 && k < 40);
      chk_val(5'(k), clocks_of(a[8:7]), "period");
      r = rnd();
      w0 = r[12:0];
      w1 = ~w1;
      w2 = ~w2;
      rt_sel = ~rt_sel;
      step(3);
      chk_cfg(cfg_o, exp_cfg(a, b, c));
      chk_val(5'(rc_freq_sel_o), 5'(b[12] ? rt_sel : b[3:2]), "rc sel");
    end
    // Supply just below each level, then the shared reset pin
    for (int lv = 0; lv < 4; lv++) begin
      load({3'h0, lv[0], 9'h000}, 13'h0600 | {11'h000, lv[1:0]}, 13'h0000);
      vdd_ok_i = 3'(((1 << lv) - 1) >> 1);
      step(3);
      chk_val(5'(core_reset_o), 5'(lv != 0), "lvr hold");
      vdd_ok_i = 3'h7;
      wait_for(0, 1'h0, 8);
      ext_reset_pin_n_i = 1'h0;
      step(3);
      chk_val(5'(core_reset_o), 5'(lv[0]), "pin reset");
      ext_reset_pin_n_i = 1'h1;
      wait_for(0, 1'h0, 8);
    end
    // Filter widths: 3 short of the threshold is dropped, 3 over is kept; with the filter bypassed a 3-period pulse is kept
    for (int j = 0; j < 12; j++) begin
      m = tbl[j / 2];
      thr = m[4] ? 8 : 32;
      filt = !m[5] && !m[3] && (m[2] || !m[1]);
      wd = (j % 2) ? thr + 3 : (filt ? thr - 3 : 3);
      load({1'h0, m[4], m[5], 4'h0, m[2:0], 3'h0}, 13'h0600, 13'h0000);
      sleep_i = m[3];
      ext_int_pin_i = 1'h0;
      pulses(1, wd, n1);
      ext_int_pin_i = 1'h1;
      pulses(1, 45, n2);
      chk_val(5'(n1 + n2), 5'((j % 2) || !filt), "int count");
    end
    sleep_i = 1'h0;
    // Comparator change awake and asleep, then disabled
    load(13'h0000, 13'h0600, 13'h0000);
    cmp_enable_i = 1'h1;
    for (int s = 0; s < 2; s++) begin
      sleep_i = s[0];
      cmp_out_i = ~cmp_out_i;
      pulses(3, 8, n1);
      chk_val(5'(n1), 5'(s), "wake count");
      chk_val(5'(cmp_flag_o), 5'h01, "cmp flag");
      cmp_flag_clr_i = 1'h1;
      step();
      cmp_flag_clr_i = 1'h0;
      step();
      chk_val(5'(cmp_flag_o), 5'h00, "flag clear");
    end
    cmp_enable_i = 1'h0;
    cmp_out_i = ~cmp_out_i;
    pulses(3, 8, n1);
    chk_val({n1[3:0], cmp_flag_o}, 5'h00, "cmp off");
    sleep_i = 1'h0;
    conclude();
  end
endmodule : owc_config_decoder_tb
